/* rtl/cfps_core_fetch.sv */
`timescale 1ns/1ps
module cfps_core_fetch (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  output logic [cfps_pkg::PC_W-1:0] O_PROG_ADDR,
  input wire logic [cfps_pkg::INSTR_W-1:0] I_PROG_DATA,
  output logic O_PHASE_ONE,
  output logic O_PHASE_TWO,
  output logic O_PHASE_THREE,
  output logic O_PHASE_FOUR,
  output logic [cfps_pkg::INSTR_W-1:0] O_INSTRUCTION_REGISTER,
  output logic [cfps_pkg::PC_W-1:0] O_EXEC_PC,
  output logic [cfps_pkg::PC_W-1:0] O_PC,
  output logic O_EXEC_VALID,
  output logic O_EXEC_NO_OPERATION,
  output logic O_SECOND_WORD,
  output logic [cfps_pkg::OPER_W-1:0] O_OPERAND,
  output logic O_OPERAND_READ,
  output logic O_DEST_WRITE,
  input wire logic I_TWO_WORD,
  input wire logic I_SKIP_NEXT,
  input wire logic I_VECTOR_REQ,
  input wire logic [cfps_pkg::PC_W-1:0] I_VECTOR_ADDR,
  input wire logic I_JUMP_ABS,
  input wire logic I_CALL,
  input wire logic [cfps_pkg::WORD_ADDR_W-1:0] I_JUMP_WORD,
  input wire logic I_BRANCH_REL,
  input wire logic [cfps_pkg::BRANCH_W-1:0] I_BRANCH_OFS,
  input wire logic I_RETURN_REQ,
  input wire logic [cfps_pkg::PC_W-1:0] I_RETURN_ADDR,
  input wire logic I_FAST,
  input wire logic I_PC_LOW_WRITE,
  input wire logic I_PC_LOW_READ,
  input wire logic [cfps_pkg::BYTE_W-1:0] I_PC_LOW_DATA,
  input wire logic I_PC_HIGH_LATCH_WE,
  input wire logic I_PC_UPPER_LATCH_WE,
  input wire logic [cfps_pkg::BYTE_W-1:0] I_LATCH_DATA,
  output logic [cfps_pkg::BYTE_W-1:0] O_PC_HIGH_LATCH,
  output logic [cfps_pkg::UPPER_W-1:0] O_PC_UPPER_LATCH,
  input wire logic I_TABLE_PTR_WE,
  input wire logic [cfps_pkg::PC_W-1:0] I_TABLE_PTR_DATA,
  input wire logic I_TABLE_READ,
  input wire logic I_TABLE_LATCH_WE,
  input wire logic [cfps_pkg::BYTE_W-1:0] I_TABLE_LATCH_DATA,
  output logic [cfps_pkg::PC_W-1:0] O_TABLE_PTR,
  output logic [cfps_pkg::BYTE_W-1:0] O_TABLE_LATCH,
  input wire logic [cfps_pkg::BYTE_W-1:0] I_STATUS,
  input wire logic [cfps_pkg::BYTE_W-1:0] I_WORKING,
  input wire logic [cfps_pkg::BANK_W-1:0] I_BANK_SELECT,
  output logic O_RESTORE,
  output logic [cfps_pkg::BYTE_W-1:0] O_RESTORE_STATUS,
  output logic [cfps_pkg::BYTE_W-1:0] O_RESTORE_WORKING,
  output logic [cfps_pkg::BANK_W-1:0] O_RESTORE_BANK_SELECT
);

  logic phase_one;
  logic phase_two;
  logic phase_three;
  logic phase_four;
  logic [cfps_pkg::PC_W-1:0] pc;
  logic [cfps_pkg::PC_W-1:0] next_pc;
  logic [cfps_pkg::PC_W-1:0] fetch_addr;
  logic [cfps_pkg::INSTR_W-1:0] fetch_buf;
  logic [cfps_pkg::PC_W-1:0] fetch_buf_pc;
  logic fetch_buf_valid;
  logic [cfps_pkg::INSTR_W-1:0] instruction_register;
  logic [cfps_pkg::PC_W-1:0] exec_pc;
  logic exec_live;
  logic second_pending;
  logic second_word;
  logic tag_word;
  logic redirect;
  logic discard;
  logic exec_end;
  logic [cfps_pkg::BYTE_W-1:0] pc_high_latch;
  logic [cfps_pkg::UPPER_W-1:0] pc_upper_latch;
  logic [cfps_pkg::PC_W-1:0] table_pointer_reg;
  logic [cfps_pkg::BYTE_W-1:0] table_latch_reg;
  logic [cfps_pkg::BYTE_W-1:0] shadow_status;
  logic [cfps_pkg::BYTE_W-1:0] shadow_working;
  logic [cfps_pkg::BANK_W-1:0] shadow_bank_select;
  logic shadow_save;
  logic shadow_load;
  logic [cfps_pkg::PC_W-1:0] branch_disp;

  // ==========================================================
  // Phase generation
  cfps_phase_gen u_phase (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .o_phase_one(phase_one),
    .o_phase_two(phase_two),
    .o_phase_three(phase_three),
    .o_phase_four(phase_four)
  );

  // ==========================================================
  // Execute stage decode
  // A tagged word is data only right after its first word
  assign tag_word = (instruction_register[cfps_pkg::TAG_HI:cfps_pkg::TAG_LO]
                     == cfps_pkg::SECOND_WORD_TAG);
  assign second_word = exec_live && tag_word && second_pending;
  assign exec_end = phase_four && exec_live && !tag_word;

  // Interrupts are taken at the cycle boundary, even in a flush cycle
  assign redirect = (phase_four && I_VECTOR_REQ) ||
                    (exec_end && (I_PC_LOW_WRITE || I_JUMP_ABS ||
                     I_CALL || I_BRANCH_REL || I_RETURN_REQ));
  assign discard = redirect || (exec_end && I_SKIP_NEXT);

  // Word count doubled to a byte displacement, sign kept
  assign branch_disp = {{(cfps_pkg::PC_W - cfps_pkg::BRANCH_W - 1)
                         {I_BRANCH_OFS[cfps_pkg::BRANCH_W-1]}},
                        I_BRANCH_OFS, 1'b0};

  always_comb begin
    next_pc = pc;
    if (phase_four && I_VECTOR_REQ) begin
      next_pc = I_VECTOR_ADDR;
    end else if (exec_end && I_PC_LOW_WRITE) begin
      next_pc = {pc_upper_latch, pc_high_latch,
                 I_PC_LOW_DATA[cfps_pkg::LOW_BYTE_HI:1], 1'b0};
    end else if (exec_end && (I_JUMP_ABS || I_CALL)) begin
      next_pc = {I_JUMP_WORD, 1'b0};
    end else if (exec_end && I_BRANCH_REL) begin
      next_pc = exec_pc + cfps_pkg::PC_STEP + branch_disp;
    end else if (exec_end && I_RETURN_REQ) begin
      next_pc = I_RETURN_ADDR;
    end else if (phase_one) begin
      next_pc = pc + cfps_pkg::PC_STEP;
    end
    next_pc[0] = 1'b0;
  end

  // ==========================================================
  // Program counter and fetch address
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      pc <= cfps_pkg::PC_RESET;
      fetch_addr <= cfps_pkg::PC_RESET;
    end else begin
      pc <= next_pc;
      if (phase_one) begin
        fetch_addr <= pc;
      end
    end
  end

  // Table reads borrow the bus in phase three only
  assign O_PROG_ADDR = (phase_three && I_TABLE_READ) ? table_pointer_reg
                                                     : fetch_addr;

  // ==========================================================
  // Fetch buffer, latched in phase four
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      fetch_buf <= cfps_pkg::FLUSH_WORD;
      fetch_buf_pc <= cfps_pkg::PC_RESET;
      fetch_buf_valid <= 1'b0;
    end else if (phase_four) begin
      fetch_buf <= I_PROG_DATA;
      fetch_buf_pc <= fetch_addr;
      fetch_buf_valid <= !discard;
    end
  end

  // ==========================================================
  // Instruction register, loaded in phase one
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      instruction_register <= cfps_pkg::FLUSH_WORD;
      exec_pc <= cfps_pkg::PC_RESET;
      exec_live <= 1'b0;
    end else if (phase_one) begin
      instruction_register <= fetch_buf;
      exec_pc <= fetch_buf_pc;
      exec_live <= fetch_buf_valid;
    end
  end

  // Marks that the word now being fetched is a genuine second word
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      second_pending <= 1'b0;
    end else if (phase_four) begin
      second_pending <= exec_end && I_TWO_WORD && !discard;
    end
  end

  // Operand is held from the second word until the next one arrives
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_OPERAND <= cfps_pkg::OPER_RESET;
    end else if (phase_two && second_word) begin
      O_OPERAND <= instruction_register[cfps_pkg::OPER_W-1:0];
    end
  end

  assign O_INSTRUCTION_REGISTER = instruction_register;
  assign O_EXEC_PC = exec_pc;
  assign O_PC = pc;
  assign O_EXEC_VALID = exec_live && !tag_word;
  assign O_EXEC_NO_OPERATION = !exec_live || (tag_word && !second_pending);
  assign O_SECOND_WORD = second_word;
  assign O_OPERAND_READ = phase_two && exec_live && !tag_word;
  assign O_DEST_WRITE = exec_end;
  assign O_PHASE_ONE = phase_one;
  assign O_PHASE_TWO = phase_two;
  assign O_PHASE_THREE = phase_three;
  assign O_PHASE_FOUR = phase_four;

  // ==========================================================
  // Counter latches for computed jumps
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      pc_high_latch <= cfps_pkg::BYTE_RESET;
      pc_upper_latch <= cfps_pkg::UPPER_RESET;
    end else if (phase_four && I_PC_HIGH_LATCH_WE) begin
      pc_high_latch <= I_LATCH_DATA;
    end else if (phase_four && I_PC_UPPER_LATCH_WE) begin
      pc_upper_latch <= I_LATCH_DATA[cfps_pkg::UPPER_W-1:0];
    end else if (phase_two && I_PC_LOW_READ && exec_live) begin
      pc_high_latch <= pc[cfps_pkg::HIGH_HI:cfps_pkg::HIGH_LO];
      pc_upper_latch <= pc[cfps_pkg::UPPER_HI:cfps_pkg::UPPER_LO];
    end
  end

  assign O_PC_HIGH_LATCH = pc_high_latch;
  assign O_PC_UPPER_LATCH = pc_upper_latch;

  // ==========================================================
  // Table pointer and latch, one byte per transfer
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      table_pointer_reg <= cfps_pkg::PC_RESET;
    end else if (phase_four && I_TABLE_PTR_WE) begin
      table_pointer_reg <= I_TABLE_PTR_DATA;
    end
  end

  // Odd pointer picks the upper byte of the addressed word
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      table_latch_reg <= cfps_pkg::BYTE_RESET;
    end else if (phase_three && I_TABLE_READ) begin
      table_latch_reg <= table_pointer_reg[0]
          ? I_PROG_DATA[cfps_pkg::INSTR_W-1:cfps_pkg::UP_BYTE_LO]
          : I_PROG_DATA[cfps_pkg::LOW_BYTE_HI:0];
    end else if (phase_four && I_TABLE_LATCH_WE) begin
      table_latch_reg <= I_TABLE_LATCH_DATA;
    end
  end

  assign O_TABLE_PTR = table_pointer_reg;
  assign O_TABLE_LATCH = table_latch_reg;

  // ==========================================================
  // Shadow registers, one level deep, no software path
  // A nested vector simply overwrites: no second level exists
  assign shadow_save = (phase_four && I_VECTOR_REQ) ||
                       (exec_end && I_CALL && I_FAST);
  assign shadow_load = exec_end && I_RETURN_REQ && I_FAST &&
                       !I_VECTOR_REQ;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      shadow_status <= cfps_pkg::BYTE_RESET;
      shadow_working <= cfps_pkg::BYTE_RESET;
      shadow_bank_select <= cfps_pkg::BANK_RESET;
    end else if (shadow_save) begin
      shadow_status <= I_STATUS;
      shadow_working <= I_WORKING;
      shadow_bank_select <= I_BANK_SELECT;
    end
  end

  // Shadow contents leave the block only with a restore strobe
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      O_RESTORE <= 1'b0;
      O_RESTORE_STATUS <= cfps_pkg::BYTE_RESET;
      O_RESTORE_WORKING <= cfps_pkg::BYTE_RESET;
      O_RESTORE_BANK_SELECT <= cfps_pkg::BANK_RESET;
    end else begin
      O_RESTORE <= shadow_load;
      if (shadow_load) begin
        O_RESTORE_STATUS <= shadow_status;
        O_RESTORE_WORKING <= shadow_working;
        O_RESTORE_BANK_SELECT <= shadow_bank_select;
      end
    end
  end

endmodule

/* common/cfps_pkg.sv */
package cfps_pkg;

  // ==========================================================
  // Widths
  localparam int PC_W = 21;
  localparam int INSTR_W = 16;
  localparam int BYTE_W = 8;
  localparam int BANK_W = 4;
  localparam int OPER_W = 12;
  localparam int BRANCH_W = 11;
  localparam int WORD_ADDR_W = 20;
  localparam int UPPER_W = 5;

  // ==========================================================
  // Field positions
  localparam int TAG_HI = 15;
  localparam int TAG_LO = 12;
  localparam int HIGH_HI = 15;
  localparam int HIGH_LO = 8;
  localparam int UPPER_HI = 20;
  localparam int UPPER_LO = 16;
  localparam int LOW_BYTE_HI = 7;
  localparam int UP_BYTE_LO = 8;

  // ==========================================================
  // Values
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
  localparam logic [INSTR_W-1:0] FLUSH_WORD = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;
  localparam logic [UPPER_W-1:0] UPPER_RESET = 5'h00;
  localparam logic [OPER_W-1:0] OPER_RESET = 12'h000;

  // ==========================================================
  // Quadrature phases of one instruction cycle
  typedef enum logic [1:0] {
    CFPS_PH_ONE,
    CFPS_PH_TWO,
    CFPS_PH_THREE,
    CFPS_PH_FOUR
  } cfps_phase_t;

endpackage

/* rtl/cfps_phase_gen.sv */
`timescale 1ns/1ps
module cfps_phase_gen (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_phase_one,
  output logic o_phase_two,
  output logic o_phase_three,
  output logic o_phase_four
);

  cfps_pkg::cfps_phase_t phase;
  cfps_pkg::cfps_phase_t next_phase;

  // ==========================================================
  // Divide by four, one phase per input clock
  always_comb begin
    case (phase)
      cfps_pkg::CFPS_PH_ONE: next_phase = cfps_pkg::CFPS_PH_TWO;
      cfps_pkg::CFPS_PH_TWO: next_phase = cfps_pkg::CFPS_PH_THREE;
      cfps_pkg::CFPS_PH_THREE: next_phase = cfps_pkg::CFPS_PH_FOUR;
      cfps_pkg::CFPS_PH_FOUR: next_phase = cfps_pkg::CFPS_PH_ONE;
      default: next_phase = cfps_pkg::CFPS_PH_ONE;
    endcase
  end

  // Reset lands in phase one so the first cycle is whole
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase <= cfps_pkg::CFPS_PH_ONE;
    end else begin
      phase <= next_phase;
    end
  end

  // Registered one-hot strobes never overlap
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_phase_one <= 1'b1;
      o_phase_two <= 1'b0;
      o_phase_three <= 1'b0;
      o_phase_four <= 1'b0;
    end else begin
      o_phase_one <= (next_phase == cfps_pkg::CFPS_PH_ONE);
      o_phase_two <= (next_phase == cfps_pkg::CFPS_PH_TWO);
      o_phase_three <= (next_phase == cfps_pkg::CFPS_PH_THREE);
      o_phase_four <= (next_phase == cfps_pkg::CFPS_PH_FOUR);
    end
  end

endmodule

/* test/cfps_core_fetch_monitor.sv */
`timescale 1ns/1ps
module cfps_core_fetch_monitor (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic O_PHASE_ONE,
  input wire logic O_PHASE_TWO,
  input wire logic O_PHASE_THREE,
  input wire logic O_PHASE_FOUR,
  input wire logic [cfps_pkg::PC_W-1:0] O_PC,
  input wire logic [cfps_pkg::INSTR_W-1:0] O_INSTRUCTION_REGISTER,
  input wire logic O_OPERAND_READ,
  input wire logic O_DEST_WRITE,
  input wire logic O_EXEC_VALID,
  input wire logic O_EXEC_NO_OPERATION,
  input wire logic O_SECOND_WORD,
  input wire logic O_RESTORE,
  input wire logic I_JUMP_ABS,
  input wire logic [cfps_pkg::WORD_ADDR_W-1:0] I_JUMP_WORD,
  input wire logic I_VECTOR_REQ,
  input wire logic I_PC_LOW_WRITE,
  input wire logic I_RETURN_REQ,
  input wire logic I_FAST
);
  // ======
  // Clocking
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);
  logic jmp;
  logic fret;
  // Higher-priority redirects excluded so the target is unambiguous
  assign jmp = O_PHASE_FOUR && O_EXEC_VALID && I_JUMP_ABS && !I_VECTOR_REQ &&
               !I_PC_LOW_WRITE;
  assign fret = O_PHASE_FOUR && O_EXEC_VALID && I_RETURN_REQ && I_FAST &&
                !I_VECTOR_REQ;
  // ======
  // Properties
  property p_ring;
    O_PHASE_ONE |=> O_PHASE_TWO ##1 O_PHASE_THREE ##1 O_PHASE_FOUR ##1
      O_PHASE_ONE;
  endproperty
  a_ring: assert property (p_ring) else $error("phase order");
  property p_pc_hold;
    O_PHASE_TWO |=> $stable(O_PC) ##1 $stable(O_PC);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved");
  property p_ir_hold;
    O_PHASE_TWO |=> $stable(O_INSTRUCTION_REGISTER) [*2];
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("ir moved");
  property p_opread;
    O_OPERAND_READ |-> O_PHASE_TWO;
  endproperty
  a_opread: assert property (p_opread) else $error("read phase");
  property p_dest;
    O_DEST_WRITE |-> O_PHASE_FOUR;
  endproperty
  a_dest: assert property (p_dest) else $error("write phase");
  property p_jump;
    jmp |=> O_PC == {$past(I_JUMP_WORD), 1'b0};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target");
  property p_flush;
    jmp |-> ##2 O_EXEC_NO_OPERATION [*3];
  endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_restore;
    fret |=> O_RESTORE ##1 !O_RESTORE;
  endproperty
  a_restore: assert property (p_restore) else $error("restore");
  property p_second;
    O_SECOND_WORD |-> O_INSTRUCTION_REGISTER[15:12] ==
      cfps_pkg::SECOND_WORD_TAG && !O_EXEC_VALID && !O_EXEC_NO_OPERATION;
  endproperty
  a_second: assert property (p_second) else $error("second word");
  c_jump: cover property (jmp);
  c_restore: cover property (O_RESTORE);
  c_second: cover property (O_SECOND_WORD);
endmodule

/* test/cfps_prog_mem_model.sv */
`timescale 1ns/1ps
module cfps_prog_mem_model (
  input wire logic [cfps_pkg::PC_W-1:0] i_addr,
  output logic [cfps_pkg::INSTR_W-1:0] o_data
);
  // ======
  // Word store
  logic [cfps_pkg::INSTR_W-1:0] mem [64];
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {8'hC0 + 8'(i), 8'(i)};
    end
    mem[5] = 16'hF456;
  end
  // Small store wraps; both bytes of a word share one even address
  assign o_data = mem[i_addr[6:1]];
endmodule

/* test/tb_cfps_core_fetch.sv */
`timescale 1ns/1ps
module tb_cfps_core_fetch;
  logic I_CLOCK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic [cfps_pkg::PC_W-1:0] O_PROG_ADDR, O_EXEC_PC, O_PC, O_TABLE_PTR;
  logic [cfps_pkg::PC_W-1:0] I_VECTOR_ADDR, I_RETURN_ADDR, I_TABLE_PTR_DATA;
  logic [cfps_pkg::INSTR_W-1:0] I_PROG_DATA, O_INSTRUCTION_REGISTER;
  logic O_PHASE_ONE, O_PHASE_TWO, O_PHASE_THREE, O_PHASE_FOUR, O_EXEC_VALID;
  logic O_EXEC_NO_OPERATION, O_SECOND_WORD, O_OPERAND_READ, O_DEST_WRITE;
  logic O_RESTORE, I_TWO_WORD, I_SKIP_NEXT, I_VECTOR_REQ, I_JUMP_ABS, I_CALL;
  logic I_BRANCH_REL, I_RETURN_REQ, I_FAST, I_PC_LOW_WRITE, I_PC_LOW_READ;
  logic I_PC_HIGH_LATCH_WE, I_PC_UPPER_LATCH_WE, I_TABLE_PTR_WE, I_TABLE_READ;
  logic I_TABLE_LATCH_WE;
  logic [cfps_pkg::OPER_W-1:0] O_OPERAND;
  logic [cfps_pkg::WORD_ADDR_W-1:0] I_JUMP_WORD;
  logic [cfps_pkg::BRANCH_W-1:0] I_BRANCH_OFS;
  logic [cfps_pkg::BYTE_W-1:0] I_PC_LOW_DATA, I_LATCH_DATA, O_PC_HIGH_LATCH;
  logic [cfps_pkg::BYTE_W-1:0] I_TABLE_LATCH_DATA, O_TABLE_LATCH, I_STATUS;
  logic [cfps_pkg::BYTE_W-1:0] I_WORKING, O_RESTORE_STATUS, O_RESTORE_WORKING;
  logic [cfps_pkg::BANK_W-1:0] I_BANK_SELECT, O_RESTORE_BANK_SELECT;
  logic [cfps_pkg::UPPER_W-1:0] O_PC_UPPER_LATCH;
  logic [3:0] ph;
  int fails = 0;
  int cmp_count = 0;
  assign ph = {O_PHASE_FOUR, O_PHASE_THREE, O_PHASE_TWO, O_PHASE_ONE};
  always #10 I_CLOCK = ~I_CLOCK;
  cfps_core_fetch uut (.*);
  cfps_prog_mem_model mem_model (.i_addr(O_PROG_ADDR), .o_data(I_PROG_DATA));
  // ======
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic idle();
    {I_TWO_WORD, I_SKIP_NEXT, I_VECTOR_REQ, I_JUMP_ABS, I_CALL} = '0;
    {I_BRANCH_REL, I_RETURN_REQ, I_FAST, I_PC_LOW_WRITE, I_PC_LOW_READ} = '0;
    {I_PC_HIGH_LATCH_WE, I_PC_UPPER_LATCH_WE, I_TABLE_PTR_WE} = '0;
    {I_TABLE_READ, I_TABLE_LATCH_WE} = '0;
    {I_VECTOR_ADDR, I_RETURN_ADDR, I_TABLE_PTR_DATA, I_JUMP_WORD} = '0;
    {I_BRANCH_OFS, I_PC_LOW_DATA, I_LATCH_DATA, I_TABLE_LATCH_DATA} = '0;
  endtask
  task automatic wait_ph(input int n);
    do begin
      @(posedge I_CLOCK);
      #1;
    end while (ph[n-1] !== 1'b1);
  endtask
  // Requests hold across exactly one sampling edge, then drop
  task automatic fire();
    @(posedge I_CLOCK);
    #1;
    idle();
  endtask
  // Jump, call, branch, return and skip controls are ignored in flushed cycles, so wait for a real one
  task automatic sync();
    do wait_ph(2); while (O_EXEC_VALID !== 1'b1);
  endtask
  // ======
  // Scenarios
  task automatic s_phase();
    logic [cfps_pkg::PC_W-1:0] pc0;
    wait_ph(2);
    pc0 = O_PC;
    wait_ph(2);
    chk("pc step", pc0 + 21'h2, O_PC);
    chk("pc lsb", 1'b0, O_PC[0]);
  endtask
  task automatic s_jump();
    sync();
    wait_ph(4);
    I_JUMP_ABS = 1'b1;
    I_JUMP_WORD = 20'h00004;
    fire();
    chk("jump pc", 21'h8, O_PC);
    wait_ph(2);
    chk("flush", 1'b1, O_EXEC_NO_OPERATION);
    wait_ph(2);
    chk("exec pc", 21'h8, O_EXEC_PC);
    chk("ir", 16'hC404, O_INSTRUCTION_REGISTER);
    wait_ph(4);
    I_TWO_WORD = 1'b1;
    fire();
    wait_ph(3);
    chk("second", 1'b1, O_SECOND_WORD);
    chk("operand", 12'h456, O_OPERAND);
  endtask
  task automatic s_branch();
    logic [cfps_pkg::PC_W-1:0] pcx;
    sync();
    pcx = O_EXEC_PC;
    wait_ph(4);
    I_BRANCH_REL = 1'b1;
    I_BRANCH_OFS = 11'h7FE;
    fire();
    wait_ph(2);
    wait_ph(2);
    chk("branch", pcx - 21'h2, O_EXEC_PC);
    sync();
    pcx = O_EXEC_PC;
    wait_ph(4);
    I_SKIP_NEXT = 1'b1;
    fire();
    wait_ph(2);
    chk("skipped", 1'b1, O_EXEC_NO_OPERATION);
    wait_ph(2);
    chk("after skip", pcx + 21'h4, O_EXEC_PC);
  endtask
  task automatic s_computed();
    sync();
    wait_ph(4);
    I_PC_HIGH_LATCH_WE = 1'b1;
    I_LATCH_DATA = 8'h01;
    fire();
    chk("high latch", 8'h01, O_PC_HIGH_LATCH);
    wait_ph(4);
    I_PC_UPPER_LATCH_WE = 1'b1;
    I_LATCH_DATA = 8'h01;
    fire();
    chk("upper latch", 5'h01, O_PC_UPPER_LATCH);
    sync();
    wait_ph(4);
    I_PC_LOW_WRITE = 1'b1;
    I_PC_LOW_DATA = 8'h0A;
    fire();
    wait_ph(2);
    wait_ph(2);
    chk("computed pc", 21'h01010A, O_EXEC_PC);
    chk("lone tag", 1'b1, O_EXEC_NO_OPERATION);
    chk("lone second", 1'b0, O_SECOND_WORD);
  endtask
  task automatic ev(input logic [3:0] kind, input logic [19:0] live);
    {I_STATUS, I_WORKING, I_BANK_SELECT} = live;
    sync();
    wait_ph(4);
    {I_VECTOR_REQ, I_CALL, I_RETURN_REQ, I_FAST} = kind;
    I_VECTOR_ADDR = 21'h000008;
    I_JUMP_WORD = 20'h00010;
    I_RETURN_ADDR = 21'h000020;
    fire();
  endtask
  task automatic s_shadow();
    logic [20:0] got;
    ev(4'b0101, 20'h11223);
    ev(4'b0100, 20'h44556);
    ev(4'b0011, 20'h00000);
    got = {O_RESTORE, O_RESTORE_STATUS, O_RESTORE_WORKING,
           O_RESTORE_BANK_SELECT};
    chk("call restore", 21'h111223, got);
    ev(4'b1000, 20'h77889);
    ev(4'b1000, 20'hAABBC);
    ev(4'b0011, 20'h00000);
    got = {O_RESTORE, O_RESTORE_STATUS, O_RESTORE_WORKING,
           O_RESTORE_BANK_SELECT};
    chk("int restore", 21'h1AABBC, got);
    ev(4'b0010, 20'h00000);
    chk("plain return", 1'b0, O_RESTORE);
  endtask
  task automatic s_table();
    sync();
    I_PC_LOW_READ = 1'b1;
    fire();
    chk("high copy", 8'h00, O_PC_HIGH_LATCH);
    chk("upper copy", 5'h00, O_PC_UPPER_LATCH);
    wait_ph(4);
    I_TABLE_PTR_WE = 1'b1;
    I_TABLE_PTR_DATA = 21'h000003;
    fire();
    chk("table ptr", 21'h3, O_TABLE_PTR);
    wait_ph(3);
    I_TABLE_READ = 1'b1;
    fire();
    chk("table read", 8'hC1, O_TABLE_LATCH);
    sync();
    wait_ph(4);
    I_TABLE_LATCH_WE = 1'b1;
    I_TABLE_LATCH_DATA = 8'h5A;
    fire();
    chk("table write", 8'h5A, O_TABLE_LATCH);
  endtask
  // ======
  // Run
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    idle();
    {I_STATUS, I_WORKING, I_BANK_SELECT} = '0;
    repeat (20) @(posedge I_CLOCK);
    #1;
    chk("reset phase", 1'b1, O_PHASE_ONE);
    chk("reset pc", 21'h0, O_PC);
    chk("reset flush", 1'b1, O_EXEC_NO_OPERATION);
    I_SYS_RST = 1'b0;
    s_phase();
    s_jump();
    s_branch();
    s_computed();
    s_shadow();
    s_table();
    close_out();
  end
  // Run needs under two hundred cycles; this only cuts a hang
  initial begin
    repeat (3000) @(posedge I_CLOCK);
    fails++;
    close_out();
  end
endmodule
bind cfps_core_fetch cfps_core_fetch_monitor mon (.*);
